// ===== core/tfg_consts.vh
// Constants of the traverse frequency generator: register offsets, reset values, timing.
// Assumes 25 MHz ref_clk; frequencies in 0.01 Hz, ratios in 0.1 %, times in 0.1 s.
`ifndef TFG_CONSTS_VH
`define TFG_CONSTS_VH

`define TFG_CLK_HZ 25000000
`define TFG_TIME_UNIT_PER_SEC 10
`define TFG_TENTH_CYCLES (`TFG_CLK_HZ / `TFG_TIME_UNIT_PER_SEC)
`define TFG_RATIO_FULL 1000
`define TFG_RATIO_MAX 16'h01F4
`define TFG_WAIT_MAX 16'hEA60
`define TFG_RAMP_MAX 16'h2710

`define TFG_OFS_FUNC_SEL 8'h00
`define TFG_OFS_PRESET_FREQ 8'h04
`define TFG_OFS_WAIT_TIME 8'h08
`define TFG_OFS_AMP_RATIO 8'h0C
`define TFG_OFS_JUMP_RATIO 8'h10
`define TFG_OFS_RISE_TIME 8'h14
`define TFG_OFS_FALL_TIME 8'h18
`define TFG_OFS_CENTRE_SET 8'h1C
`define TFG_OFS_FREQ_SET 8'h20
`define TFG_OFS_MAX_FREQ 8'h24
`define TFG_OFS_UPPER_LIMIT 8'h28
`define TFG_OFS_STATUS 8'h2C

`define TFG_RST_FUNC_SEL 16'h0000
`define TFG_RST_PRESET_FREQ 16'h03E8
`define TFG_RST_WAIT_TIME 16'h0000
`define TFG_RST_AMP_RATIO 16'h0064
`define TFG_RST_JUMP_RATIO 16'h0064
`define TFG_RST_RISE_TIME 16'h0064
`define TFG_RST_FALL_TIME 16'h0064
`define TFG_RST_CENTRE_SET 16'h03E8
`define TFG_RST_FREQ_SET 16'h0000
`define TFG_RST_MAX_FREQ 16'h1388
`define TFG_RST_UPPER_LIMIT 16'h1388

`define TFG_MODE_OFF 4'h0
`define TFG_MODE_ALWAYS 4'h1
`define TFG_MODE_TERMINAL 4'h2
`define TFG_AMP_VAR_BIT 8

`endif

// ===== core/tfg_tick_gen.v
// Tenth-of-a-second tick generator for the traverse frequency generator.
// Assumes a synchronous clear and a clock enable from the parent.
`timescale 1ns/1ps
module tfg_tick_gen #(
    parameter PERIOD = 2500000
) (
    input wire ref_clk,
    input wire rst_b,
    input wire ce,
    input wire clear,
    output reg tick
);
    reg [31:0] count;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h00000000;
            tick <= 1'b0;
        end else if (ce) begin
            if (clear || count == PERIOD - 1) begin
                count <= 32'h00000000;
            end else begin
                count <= count + 32'h00000001;
            end
            tick <= !clear && (count == PERIOD - 1);
        end
    end
endmodule // tfg_tick_gen

// ===== core/tfg_traverse_generator.v
// Traverse (swing) frequency generator with its APB register file.
// Assumes APB master on ref_clk; runCmd and swingInput synchronous to ref_clk.
// What this block does
// - Low digit selects off, always, terminal
// - Terminal mode: swing when active, else preset
// - Always mode: preset for wait, then swing
// - Preset frequency before and outside swing
// - Fixed amplitude: ratio times maximum frequency
// - Variable amplitude: ratio times centre plus set
// - Jump down at upper, up at lower
// - Lower to upper in rise time
// - Upper to lower in fall time
// - Centre is centre setting plus set value
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "tfg_consts.vh"
module tfg_traverse_generator #(
    parameter TENTH_CYCLES = `TFG_TENTH_CYCLES
) (
    input wire ref_clk,
    input wire rst_b,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire runCmd,
    input wire swingInput,
    output reg [15:0] freqOut,
    output reg swingActive
);
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_RISE = 3'h2;
    localparam ST_FALL = 3'h3;
    localparam ST_PRESET = 3'h4;
    localparam ST_PASS = 3'h5;
    // Full 32 bits kept; the ramp products are formed at 40 bits below
    localparam [31:0] TENTH = TENTH_CYCLES;

    reg [15:0] funcSel;
    reg [15:0] presetFreq;
    reg [15:0] waitTime;
    reg [15:0] ampRatio;
    reg [15:0] jumpRatio;
    reg [15:0] riseTime;
    reg [15:0] fallTime;
    reg [15:0] centreSet;
    reg [15:0] freqSet;
    reg [15:0] maxFreq;
    reg [15:0] upperLimit;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [15:0] next_freq;
    reg [15:0] waitCount;
    reg [15:0] next_waitCount;
    reg [39:0] acc;
    reg [39:0] next_acc;
    reg mapped;
    reg [15:0] rdWord;

    wire access = psel && penable && ce;
    wire wrEn = access && pwrite;
    wire [3:0] mode = funcSel[3:0];
    wire tick;
    wire waitClear = (state != ST_WAIT);

    // No wait states; a low clock enable stalls the bus as well
    assign pready = ce;
    assign pslverr = psel && penable && !mapped;

    // Tick count restarts on each wait entry, so a wait is never cut short
    tfg_tick_gen #(
        .PERIOD(TENTH_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .clear(waitClear),
        .tick(tick)
    );

    // Writes above the documented ranges are clipped, so the arithmetic never overflows
    function [15:0] clip;
        input [15:0] v;
        input [15:0] lim;
        begin
            clip = (v > lim) ? lim : v;
        end
    endfunction

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            funcSel <= `TFG_RST_FUNC_SEL;
            presetFreq <= `TFG_RST_PRESET_FREQ;
            waitTime <= `TFG_RST_WAIT_TIME;
            ampRatio <= `TFG_RST_AMP_RATIO;
            jumpRatio <= `TFG_RST_JUMP_RATIO;
            riseTime <= `TFG_RST_RISE_TIME;
            fallTime <= `TFG_RST_FALL_TIME;
            centreSet <= `TFG_RST_CENTRE_SET;
            freqSet <= `TFG_RST_FREQ_SET;
            maxFreq <= `TFG_RST_MAX_FREQ;
            upperLimit <= `TFG_RST_UPPER_LIMIT;
        end else if (wrEn) begin
            case (paddr)
                `TFG_OFS_FUNC_SEL: funcSel <= pwdata[15:0];
                `TFG_OFS_PRESET_FREQ: presetFreq <= clip(pwdata[15:0], upperLimit);
                `TFG_OFS_WAIT_TIME: waitTime <= clip(pwdata[15:0], `TFG_WAIT_MAX);
                `TFG_OFS_AMP_RATIO: ampRatio <= clip(pwdata[15:0], `TFG_RATIO_MAX);
                `TFG_OFS_JUMP_RATIO: jumpRatio <= clip(pwdata[15:0], `TFG_RATIO_MAX);
                `TFG_OFS_RISE_TIME: riseTime <= clip(pwdata[15:0], `TFG_RAMP_MAX);
                `TFG_OFS_FALL_TIME: fallTime <= clip(pwdata[15:0], `TFG_RAMP_MAX);
                `TFG_OFS_CENTRE_SET: centreSet <= clip(pwdata[15:0], upperLimit);
                `TFG_OFS_FREQ_SET: freqSet <= pwdata[15:0];
                `TFG_OFS_MAX_FREQ: maxFreq <= pwdata[15:0];
                `TFG_OFS_UPPER_LIMIT: upperLimit <= pwdata[15:0];
                default: upperLimit <= upperLimit;
            endcase
        end
    end

    always @* begin
        mapped = 1'b1;
        rdWord = 16'h0000;
        case (paddr)
            `TFG_OFS_FUNC_SEL: rdWord = funcSel;
            `TFG_OFS_PRESET_FREQ: rdWord = presetFreq;
            `TFG_OFS_WAIT_TIME: rdWord = waitTime;
            `TFG_OFS_AMP_RATIO: rdWord = ampRatio;
            `TFG_OFS_JUMP_RATIO: rdWord = jumpRatio;
            `TFG_OFS_RISE_TIME: rdWord = riseTime;
            `TFG_OFS_FALL_TIME: rdWord = fallTime;
            `TFG_OFS_CENTRE_SET: rdWord = centreSet;
            `TFG_OFS_FREQ_SET: rdWord = freqSet;
            `TFG_OFS_MAX_FREQ: rdWord = maxFreq;
            `TFG_OFS_UPPER_LIMIT: rdWord = upperLimit;
            `TFG_OFS_STATUS: rdWord = freqOut;
            default: mapped = 1'b0;
        endcase
    end

    // Status word carries the state code above the live frequency
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable && !pwrite) begin
            if (paddr == `TFG_OFS_STATUS) begin
                prdata <= {13'h0000, state, rdWord};
            end else begin
                prdata <= {16'h0000, rdWord};
            end
        end
    end

    // Boundary arithmetic, all by constant division; a fresh word every cycle
    // Limits follow a later drop of the upper frequency limit too
    wire [15:0] presetEff = (presetFreq > upperLimit) ? upperLimit : presetFreq;
    wire [15:0] centreEff = (centreSet > upperLimit) ? upperLimit : centreSet;
    wire [16:0] centre = {1'b0, centreEff} + {1'b0, freqSet};
    wire [16:0] ampBase = funcSel[`TFG_AMP_VAR_BIT] ? centre : {1'b0, maxFreq};
    wire [32:0] ampProd = ampBase * ampRatio;
    wire [32:0] ampQuot = ampProd / `TFG_RATIO_FULL;
    // Ratio capped at half scale, so the quotient always fits 17 bits
    wire [16:0] amp = ampQuot[16:0];
    wire [32:0] jumpProd = amp * jumpRatio;
    wire [32:0] jumpQuot = jumpProd / `TFG_RATIO_FULL;
    wire [16:0] jump = jumpQuot[16:0];
    wire [17:0] highRaw = {1'b0, centre} + {1'b0, amp};
    wire [15:0] high = (highRaw > 18'h0FFFF) ? 16'hFFFF : highRaw[15:0];
    wire [15:0] low = (amp >= centre) ? 16'h0000 : centre[15:0] - amp[15:0];
    // Jumps clamp to the far boundary when the jump exceeds the span
    wire [17:0] upAfterJump = {2'b00, low} + {1'b0, jump};
    wire [15:0] lowJump = (upAfterJump > {2'b00, high}) ? high : upAfterJump[15:0];
    wire [15:0] highJump = (jump >= {1'b0, high} - {1'b0, low}) ? low : high - jump[15:0];
    wire [15:0] span = high - low;
    wire [39:0] risePeriod = {24'h000000, riseTime} * {8'h00, TENTH};
    wire [39:0] fallPeriod = {24'h000000, fallTime} * {8'h00, TENTH};
    wire [39:0] accStep = acc + {24'h000000, span};
    wire waitDone = (waitCount >= waitTime);
    // A zero ramp time means an instant jump rather than a stalled ramp
    wire atTop = (freqOut >= high) || (riseTime == 16'h0000);
    wire atBottom = (freqOut <= low) || (fallTime == 16'h0000);
    wire swingWanted = (mode == `TFG_MODE_ALWAYS) ||
        (mode == `TFG_MODE_TERMINAL && swingInput);
    wire [15:0] centreOut = (centre > 17'h0FFFF) ? 16'hFFFF : centre[15:0];

    always @* begin
        next_state = state;
        next_freq = freqOut;
        next_acc = acc;
        next_waitCount = waitCount;
        case (state)
            ST_IDLE: begin
                next_freq = 16'h0000;
                if (runCmd) begin
                    if (mode == `TFG_MODE_ALWAYS) begin
                        next_state = ST_WAIT;
                        next_waitCount = 16'h0000;
                    end else if (mode == `TFG_MODE_TERMINAL) begin
                        next_state = ST_PRESET;
                    end else begin
                        next_state = ST_PASS;
                    end
                    next_freq = presetEff;
                end
            end
            ST_WAIT: begin
                next_freq = presetEff;
                if (waitDone) begin
                    next_state = ST_RISE;
                    next_freq = centreOut;
                    next_acc = 40'h0000000000;
                end else if (tick) begin
                    next_waitCount = waitCount + 16'h0001;
                end
            end
            ST_PRESET: begin
                // The wait time plays no part in terminal mode
                next_freq = presetEff;
                if (swingInput) begin
                    next_state = ST_RISE;
                    next_freq = centreOut;
                    next_acc = 40'h0000000000;
                end
            end
            ST_RISE: begin
                if (atTop) begin
                    next_freq = highJump;
                    next_state = ST_FALL;
                    next_acc = 40'h0000000000;
                end else if (accStep >= risePeriod) begin
                    // One unit per cycle at most; with the default TENTH_CYCLES the period always exceeds span here
                    next_acc = accStep - risePeriod;
                    next_freq = freqOut + 16'h0001;
                end else begin
                    next_acc = accStep;
                end
            end
            ST_FALL: begin
                if (atBottom) begin
                    next_freq = lowJump;
                    next_state = ST_RISE;
                    next_acc = 40'h0000000000;
                end else if (accStep >= fallPeriod) begin
                    next_acc = accStep - fallPeriod;
                    next_freq = freqOut - 16'h0001;
                end else begin
                    next_acc = accStep;
                end
            end
            ST_PASS: begin
                // Traverse off: the set value passes straight through
                next_freq = freqSet;
                if (mode != `TFG_MODE_OFF) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Leaving swing falls back to the preset frequency; a stop always wins
        if (state == ST_RISE || state == ST_FALL) begin
            if (!swingWanted) begin
                next_state = (mode == `TFG_MODE_TERMINAL) ? ST_PRESET : ST_IDLE;
                next_freq = presetEff;
            end
        end
        if (state == ST_WAIT && mode != `TFG_MODE_ALWAYS) begin
            next_state = ST_IDLE;
        end
        if (state == ST_PRESET && mode != `TFG_MODE_TERMINAL) begin
            next_state = ST_IDLE;
        end
        if (!runCmd) begin
            next_state = ST_IDLE;
            next_freq = 16'h0000;
        end
    end

    // Swing flag is taken from the next state so it lines up with freqOut

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            freqOut <= 16'h0000;
            acc <= 40'h0000000000;
            waitCount <= 16'h0000;
            swingActive <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            freqOut <= next_freq;
            acc <= next_acc;
            waitCount <= next_waitCount;
            swingActive <= (next_state == ST_RISE) || (next_state == ST_FALL);
        end
    end
endmodule // tfg_traverse_generator

// ===== dv/tfg_drive_model.sv
// Drive-side model: watches the frequency reference it is handed.
// Assumes clr is a one-cycle pulse from the bench before each swing window.
`timescale 1ns/1ps
module tfg_drive_model (
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic [15:0] freqOut,
    input wire logic swingActive,
    output logic [15:0] hi,
    output logic [15:0] lo,
    output logic [15:0] drop,
    output logic [15:0] per
);
    logic [15:0] last;
    logic [15:0] cnt;
    always @(posedge ref_clk) begin
        last <= freqOut;
        cnt <= cnt + 16'h0001;
        if (clr) begin
            hi <= 16'h0000;
            lo <= 16'hFFFF;
            drop <= 16'h0000;
            cnt <= 16'h0000;
        end else if (swingActive) begin
            if (freqOut > hi) hi <= freqOut;
            if (freqOut < lo) lo <= freqOut;
            // Ramp steps are one unit, so a larger fall is the jump
            if (last > freqOut + 16'h0001) begin
                drop <= last - freqOut;
                per <= cnt;
                cnt <= 16'h0000;
            end
        end
    end
endmodule // tfg_drive_model

// ===== dv/tfg_traverse_properties.sv
// Port checker for the traverse generator, bound to its top module.
// Assumes registers change only by APB writes; shadows them from the bus.
`timescale 1ns/1ps
`include "tfg_consts.vh"
module tfg_traverse_properties #(parameter TENTH_CYCLES = 4) (
    input wire ref_clk,
    input wire rst_b,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire runCmd,
    input wire swingInput,
    input wire [15:0] freqOut,
    input wire swingActive
);
    logic [15:0] fs, pf, cs, fv, mf, ar, jr;
    wire [16:0] mid = cs + fv;
    wire [32:0] prod = {16'h0000, fs[`TFG_AMP_VAR_BIT] ? mid : {1'b0, mf}} * ar;
    wire [16:0] amp = 17'(prod / `TFG_RATIO_FULL);
    wire [32:0] jprod = {16'h0000, amp} * jr;
    wire [16:0] jmp = 17'(jprod / `TFG_RATIO_FULL);
    wire [16:0] up = mid + amp;
    wire [16:0] lo = mid - amp;
    wire gateOn = ce && fs[3:0] == 4'h2 && runCmd;
    wire offRun = ce && fs[3:0] == 4'h0 && runCmd;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs <= `TFG_RST_FUNC_SEL;
            pf <= `TFG_RST_PRESET_FREQ;
            cs <= `TFG_RST_CENTRE_SET;
            fv <= `TFG_RST_FREQ_SET;
            mf <= `TFG_RST_MAX_FREQ;
            ar <= `TFG_RST_AMP_RATIO;
            jr <= `TFG_RST_JUMP_RATIO;
        end else if (psel && penable && pwrite && ce) begin
            case (paddr)
                `TFG_OFS_FUNC_SEL: fs <= pwdata[15:0];
                `TFG_OFS_PRESET_FREQ: pf <= pwdata[15:0];
                `TFG_OFS_CENTRE_SET: cs <= pwdata[15:0];
                `TFG_OFS_FREQ_SET: fv <= pwdata[15:0];
                `TFG_OFS_MAX_FREQ: mf <= pwdata[15:0];
                `TFG_OFS_AMP_RATIO:
                    ar <= (pwdata[15:0] > `TFG_RATIO_MAX) ? `TFG_RATIO_MAX : pwdata[15:0];
                `TFG_OFS_JUMP_RATIO:
                    jr <= (pwdata[15:0] > `TFG_RATIO_MAX) ? `TFG_RATIO_MAX : pwdata[15:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_idle_zero_out: assert property (ce && !runCmd
        |=> freqOut == 16'h0000 && !swingActive) else $error("output not zero while stopped");
    a_wait_shows_preset: assert property (ce && fs[3:0] == 4'h1 && $rose(runCmd)
        |=> freqOut == pf) else $error("run start did not give preset");
    a_gate_low_preset: assert property ((gateOn && !swingInput)[*4]
        |-> freqOut == pf && !swingActive) else $error("gated off but not preset");
    a_gate_high_swing: assert property ((gateOn && swingInput)[*4]
        |-> swingActive) else $error("gated on but no swing");
    a_entry_at_centre: assert property ($rose(swingActive) |-> freqOut == mid)
        else $error("swing entry not at centre");
    a_swing_in_band: assert property (swingActive |-> freqOut <= up && freqOut >= lo)
        else $error("swing left its band");
    a_jump_at_top: assert property (ce && swingActive && runCmd && freqOut == up
        |=> freqOut == up - jmp) else $error("no jump down at upper boundary");
    a_jump_at_bottom: assert property (ce && swingActive && runCmd && freqOut == lo
        |=> freqOut == lo + jmp) else $error("no jump up at lower boundary");
    a_mode_off_set: assert property ((offRun && $stable(fv))[*4]
        |-> freqOut == fv && !swingActive) else $error("mode off not at set value");
    c_swing_entry: cover property ($rose(swingActive));
    c_top_reached: cover property (swingActive && freqOut == up);
    c_gate_rise: cover property (fs[3:0] == 4'h2 && runCmd && $rose(swingInput));
endmodule // tfg_traverse_properties

bind tfg_traverse_generator tfg_traverse_properties #(.TENTH_CYCLES(TENTH_CYCLES)) uChk (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .runCmd(runCmd),
    .swingInput(swingInput), .freqOut(freqOut), .swingActive(swingActive));

// ===== dv/tfg_traverse_generator_bench.sv
// Bench for the traverse generator: APB tasks, run and terminal stimulus.
// Assumes a short tenth-second count so a swing period is some hundreds of cycles.
`timescale 1ns/1ps
`include "tfg_consts.vh"
module tfg_traverse_generator_bench;
    logic ref_clk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic runCmd = 0, swingInput = 0, clr = 0, pready, pslverr, swingActive, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [15:0] freqOut, hi, lo, drop, per;
    int nFail = 0, checksDone = 0, cyc = 0;
    tfg_traverse_generator #(.TENTH_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .runCmd(runCmd), .swingInput(swingInput), .freqOut(freqOut),
        .swingActive(swingActive));
    tfg_drive_model uModel (.ref_clk(ref_clk), .clr(clr), .freqOut(freqOut),
        .swingActive(swingActive), .hi(hi), .lo(lo), .drop(drop), .per(per));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic finishTest;
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Starts on its own edge so back-to-back calls never drive psel twice in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rdat = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic swing(input logic [15:0] c, input logic [15:0] u, input logic [15:0] l,
                         input logic [15:0] j);
        int n;
        @(posedge ref_clk);
        runCmd <= 1;
        repeat (2) @(posedge ref_clk);
        chk(freqOut, 16'h02BC);
        chk(swingActive, 1'b0);
        n = 0;
        while (swingActive !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n >= 8 && n <= 12, 1'b1);
        chk(freqOut, c);
        clr <= 1;
        @(posedge ref_clk);
        clr <= 0;
        repeat (1800) @(posedge ref_clk);
        chk(hi, u);
        chk(lo, l);
        chk(drop, j);
        chk(per >= 16'h02E4 && per <= 16'h030C, 1'b1);
        runCmd <= 0;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            nFail++;
            finishTest;
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1;
        rdc(`TFG_OFS_PRESET_FREQ, 32'h3E8);
        rdc(`TFG_OFS_AMP_RATIO, 32'h64);
        rdc(`TFG_OFS_JUMP_RATIO, 32'h64);
        rdc(`TFG_OFS_RISE_TIME, 32'h64);
        rdc(`TFG_OFS_FALL_TIME, 32'h64);
        rdc(`TFG_OFS_CENTRE_SET, 32'h3E8);
        rdc(8'h30, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1, `TFG_OFS_PRESET_FREQ, 32'h2BC);
        xfer(1, `TFG_OFS_WAIT_TIME, 32'h2);
        xfer(1, `TFG_OFS_AMP_RATIO, 32'hA);
        xfer(1, `TFG_OFS_FUNC_SEL, 32'h1);
        swing(16'h03E8, 16'h041A, 16'h03B6, 16'h0005);
        xfer(1, `TFG_OFS_FREQ_SET, 32'h3E8);
        xfer(1, `TFG_OFS_FUNC_SEL, 32'h101);
        swing(16'h07D0, 16'h07E4, 16'h07BC, 16'h0002);
        xfer(1, `TFG_OFS_FUNC_SEL, 32'h2);
        runCmd <= 1;
        repeat (6) @(posedge ref_clk);
        chk(freqOut, 16'h02BC);
        swingInput <= 1;
        repeat (2) @(posedge ref_clk);
        chk(swingActive, 1'b1);
        chk(freqOut, 16'h07D0);
        xfer(1, `TFG_OFS_FUNC_SEL, 32'h0);
        xfer(1, `TFG_OFS_FREQ_SET, 32'h4D2);
        repeat (5) @(posedge ref_clk);
        chk(freqOut, 16'h04D2);
        chk(swingActive, 1'b0);
        rdc(`TFG_OFS_STATUS, 32'h000504D2);
        xfer(1, `TFG_OFS_AMP_RATIO, 32'h3E8);
        rdc(`TFG_OFS_AMP_RATIO, 32'h1F4);
        ce <= 0;
        runCmd <= 0;
        repeat (2) @(posedge ref_clk);
        chk(freqOut, 16'h04D2);
        chk(pready, 1'b0);
        ce <= 1;
        repeat (2) @(posedge ref_clk);
        chk(freqOut, 16'h0000);
        finishTest;
    end
endmodule // tfg_traverse_generator_bench
